/* File: include/rtseq_defs.svh */
// constants for the radio top sequencer: offsets, fields, resets, timing
`ifndef RTSEQ_DEFS_SVH
`define RTSEQ_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RTSEQ_OFS_CTRL 12'h000
`define RTSEQ_OFS_CFG 12'h004
`define RTSEQ_OFS_FIRST_INTERVAL_TIMER 12'h008
`define RTSEQ_OFS_SECOND_INTERVAL_TIMER 12'h00c
`define RTSEQ_OFS_RXTO 12'h010
`define RTSEQ_OFS_STATUS 12'h014

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define RTSEQ_CTRL_START 0
`define RTSEQ_CTRL_HALT 1
`define RTSEQ_CTRL_BEACON 2
`define RTSEQ_CTRL_ROUTE 3

// ----------------------------------------------------------------
// config register fields
// ----------------------------------------------------------------
`define RTSEQ_CFG_IDLE_POWER 0
`define RTSEQ_CFG_START_LO 1
`define RTSEQ_CFG_START_HI 2
`define RTSEQ_CFG_LOW_POWER 3
`define RTSEQ_CFG_IDLE_EXIT 4
`define RTSEQ_CFG_RX_EXIT_LO 5
`define RTSEQ_CFG_RX_EXIT_HI 7
`define RTSEQ_CFG_RXTO_LO 8
`define RTSEQ_CFG_RXTO_HI 9
`define RTSEQ_CFG_TX_EXIT 10
`define RTSEQ_CFG_RESET 11'h000

// ----------------------------------------------------------------
// transition codes
// ----------------------------------------------------------------
`define RTSEQ_START_TO_LPSEL 2'h0
`define RTSEQ_RX_EXIT_PREAMBLE 3'h6
`define RTSEQ_RX_EXIT_SYNC 3'h5
`define RTSEQ_RXTO_TO_LPSEL 2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTSEQ_CLK_MHZ 50
`define RTSEQ_TIMER_RESET 16'h0001
`define RTSEQ_RXTO_RESET 16'h0001

`endif

/* File: include/rtseq_pkg.sv */
// types shared by the radio top sequencer
package rtseq_pkg;
	typedef enum logic [6:0] {
		RTSEQ_OFF = 7'h01,
		RTSEQ_START = 7'h02,
		RTSEQ_LPSEL = 7'h04,
		RTSEQ_IDLE = 7'h08,
		RTSEQ_RX = 7'h10,
		RTSEQ_TX = 7'h20,
		RTSEQ_LOWPWR = 7'h40
	} rtseq_state_t;
endpackage

/* File: verilog/rtseq_timer.sv */
// one programmable interval down-counter
`timescale 1ns/1ns
`default_nettype none
module rtseq_timer #(
	parameter int W = 16
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, low
	input wire logic load, // start a new interval
	input wire logic stop, // abandon the interval
	input wire logic [W-1:0] period, // interval length in ticks
	input wire logic tick, // slow time base
	output logic expired // one-cycle end pulse
);
	logic [W-1:0] count_ff;
	logic run_ff;

	// ---------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------
	// zero period is treated as one tick so the event always fires
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_ff <= '0;
			run_ff <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (stop) begin
				run_ff <= 1'b0;
			end else if (load) begin
				count_ff <= (period == '0) ? W'(1) : period;
				run_ff <= 1'b1;
			end else if (run_ff && tick) begin
				if (count_ff == W'(1)) begin
					run_ff <= 1'b0;
					expired <= 1'b1;
				end else begin
					count_ff <= count_ff - W'(1);
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: verilog/rtseq_top.sv */
// radio top sequencer with ahb-lite register slave
// Summary of operation
// - idle power choice 1 keeps only the rc oscillator on in idle
// - start transition 00 moves start to the low-power choice step
// - low-power choice 1 enters idle from the choice step
// - idle exit 1 moves idle to receive on first timer event
// - listen idles first timer, receives second timer, then idles again
// - receive exit 110: preamble switches sequencer off, radio stays receiving
// - second timer bounds receive time when no preamble is found
// - sync-wake receives only for rx window, low power otherwise
// - preamble before window end keeps receiving until second timer ends
// - receive exit 101: sync match flags and switches sequencer off
// - rx timeout transition 10 returns to the low-power choice step
// - packet received during listen raises an interrupt request
// - beacon transmits every period, idles after packet done
// - beacon repeat resends unchanged buffer contents
// - beacon loop runs until the halt bit is set
// - idle exit 0 moves idle to transmit on first timer event
// - transmit exit 0 returns to choice step on packet done
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "rtseq_defs.svh"
module rtseq_top #(
	parameter int TW = 16, // timer width
	parameter int RC_DIV = 50 // hclk cycles per rc tick
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, low
	input wire logic hsel, // slave select
	input wire logic [11:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write strobe
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready in
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic preamble_found, // radio event pulse
	input wire logic sync_word_match, // radio event pulse
	input wire logic payload_complete, // radio event pulse
	input wire logic packet_done, // radio event pulse
	output logic rx_on, // receiver enabled
	output logic tx_on, // transmitter enabled
	output logic rc_osc_on, // rc oscillator enabled
	output logic xtal_on, // crystal and radio path on
	output logic beacon_repeat_enable, // resend buffer unchanged
	output logic event_pin_four, // preamble event pin
	output logic packet_irq // packet received request
);
	rtseq_pkg::rtseq_state_t state_ff, nxt_state;
	logic [10:0] cfg_ff;
	logic [3:0] ctrl_ff;
	logic [TW-1:0] t1_per_ff, t2_per_ff, rxto_per_ff;
	logic [7:0] rc_cnt_ff;
	logic rc_tick;
	logic pre_seen_ff, sync_flag_ff, irq_ff, listen_ff;
	logic wr_pend_ff;
	logic [11:0] wr_addr_ff;
	logic t1_exp, t2_exp, rxto_exp;
	logic t1_load, t2_load, rxto_load, tstop;
	logic start_pulse;
	logic rx_exit_pre, rx_exit_sync;

	// ---------------------------------------------------------------
	// rc time base
	// ---------------------------------------------------------------
	// the rc oscillator is modelled as a divided tick of hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rc_cnt_ff <= 8'h00;
		end else if (rc_cnt_ff == 8'(RC_DIV - 1)) begin
			rc_cnt_ff <= 8'h00;
		end else begin
			rc_cnt_ff <= rc_cnt_ff + 8'h01;
		end
	end
	assign rc_tick = (rc_cnt_ff == 8'(RC_DIV - 1));

	// ---------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// ---------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// capture write address phase; data follows next cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 12'h000;
		end else if (hready) begin
			wr_pend_ff <= hsel && htrans[1] && hwrite;
			wr_addr_ff <= haddr;
		end
	end

	// read data registered in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			if (haddr == `RTSEQ_OFS_CTRL) begin
				hrdata <= {28'h0000000, ctrl_ff};
			end else if (haddr == `RTSEQ_OFS_CFG) begin
				hrdata <= {21'h000000, cfg_ff};
			end else if (haddr == `RTSEQ_OFS_FIRST_INTERVAL_TIMER) begin
				hrdata <= 32'(t1_per_ff);
			end else if (haddr == `RTSEQ_OFS_SECOND_INTERVAL_TIMER) begin
				hrdata <= 32'(t2_per_ff);
			end else if (haddr == `RTSEQ_OFS_RXTO) begin
				hrdata <= 32'(rxto_per_ff);
			end else if (haddr == `RTSEQ_OFS_STATUS) begin
				hrdata <= {22'h000000, irq_ff, sync_flag_ff, pre_seen_ff, state_ff};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// configuration writes; start bit self clears
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff <= `RTSEQ_CFG_RESET;
			ctrl_ff <= 4'h0;
			t1_per_ff <= TW'(`RTSEQ_TIMER_RESET);
			t2_per_ff <= TW'(`RTSEQ_TIMER_RESET);
			rxto_per_ff <= TW'(`RTSEQ_RXTO_RESET);
		end else begin
			ctrl_ff[`RTSEQ_CTRL_START] <= 1'b0;
			if (wr_pend_ff) begin
				if (wr_addr_ff == `RTSEQ_OFS_CTRL) begin
					ctrl_ff <= hwdata[3:0];
				end else if (wr_addr_ff == `RTSEQ_OFS_CFG) begin
					cfg_ff <= hwdata[10:0];
				end else if (wr_addr_ff == `RTSEQ_OFS_FIRST_INTERVAL_TIMER) begin
					t1_per_ff <= hwdata[TW-1:0];
				end else if (wr_addr_ff == `RTSEQ_OFS_SECOND_INTERVAL_TIMER) begin
					t2_per_ff <= hwdata[TW-1:0];
				end else if (wr_addr_ff == `RTSEQ_OFS_RXTO) begin
					rxto_per_ff <= hwdata[TW-1:0];
				end
			end
		end
	end
	assign start_pulse = ctrl_ff[`RTSEQ_CTRL_START];

	// ---------------------------------------------------------------
	// interval timers
	// ---------------------------------------------------------------
	// t1 times idle, t2 times the active slot, rxto the rx window
	rtseq_timer #(.W(TW)) u_t1 (
		.hclk(hclk), .hresetn(hresetn), .load(t1_load), .stop(tstop),
		.period(t1_per_ff), .tick(rc_tick), .expired(t1_exp)
	);
	rtseq_timer #(.W(TW)) u_t2 (
		.hclk(hclk), .hresetn(hresetn), .load(t2_load), .stop(tstop),
		.period(t2_per_ff), .tick(rc_tick), .expired(t2_exp)
	);
	rtseq_timer #(.W(TW)) u_rxto (
		.hclk(hclk), .hresetn(hresetn), .load(rxto_load), .stop(tstop),
		.period(rxto_per_ff), .tick(rc_tick), .expired(rxto_exp)
	);

	// ---------------------------------------------------------------
	// sequencer state machine
	// ---------------------------------------------------------------
	assign rx_exit_pre = (cfg_ff[`RTSEQ_CFG_RX_EXIT_HI:`RTSEQ_CFG_RX_EXIT_LO]
		== `RTSEQ_RX_EXIT_PREAMBLE);
	assign rx_exit_sync = (cfg_ff[`RTSEQ_CFG_RX_EXIT_HI:`RTSEQ_CFG_RX_EXIT_LO]
		== `RTSEQ_RX_EXIT_SYNC);

	always_comb begin
		nxt_state = state_ff;
		t1_load = 1'b0;
		t2_load = 1'b0;
		rxto_load = 1'b0;
		tstop = 1'b0;
		case (state_ff)
			rtseq_pkg::RTSEQ_OFF: begin
				if (start_pulse) begin
					nxt_state = rtseq_pkg::RTSEQ_START;
				end
			end
			rtseq_pkg::RTSEQ_START: begin
				if (cfg_ff[`RTSEQ_CFG_START_HI:`RTSEQ_CFG_START_LO] == `RTSEQ_START_TO_LPSEL) begin
					nxt_state = rtseq_pkg::RTSEQ_LPSEL;
				end
			end
			rtseq_pkg::RTSEQ_LPSEL: begin
				t1_load = 1'b1;
				if (cfg_ff[`RTSEQ_CFG_LOW_POWER]) begin
					nxt_state = rtseq_pkg::RTSEQ_IDLE;
				end else begin
					nxt_state = rtseq_pkg::RTSEQ_LOWPWR;
				end
			end
			rtseq_pkg::RTSEQ_IDLE, rtseq_pkg::RTSEQ_LOWPWR: begin
				if (t1_exp) begin
					t2_load = 1'b1;
					if (cfg_ff[`RTSEQ_CFG_IDLE_EXIT]) begin
						nxt_state = rtseq_pkg::RTSEQ_RX;
						rxto_load = 1'b1;
					end else begin
						nxt_state = rtseq_pkg::RTSEQ_TX;
					end
				end
			end
			rtseq_pkg::RTSEQ_RX: begin
				if (rx_exit_pre && preamble_found) begin
					nxt_state = rtseq_pkg::RTSEQ_OFF;
					tstop = 1'b1;
				end else if (rx_exit_sync && sync_word_match) begin
					nxt_state = rtseq_pkg::RTSEQ_OFF;
					tstop = 1'b1;
				end else if (rxto_exp && !pre_seen_ff && !preamble_found
					&& cfg_ff[`RTSEQ_CFG_RXTO_HI:`RTSEQ_CFG_RXTO_LO] == `RTSEQ_RXTO_TO_LPSEL) begin
					nxt_state = rtseq_pkg::RTSEQ_LPSEL;
					tstop = 1'b1;
				end else if (t2_exp) begin
					nxt_state = rtseq_pkg::RTSEQ_LPSEL;
					tstop = 1'b1;
				end
			end
			rtseq_pkg::RTSEQ_TX: begin
				if (packet_done && !cfg_ff[`RTSEQ_CFG_TX_EXIT]) begin
					nxt_state = rtseq_pkg::RTSEQ_LPSEL;
					tstop = 1'b1;
				end
			end
			default: begin
				nxt_state = rtseq_pkg::RTSEQ_OFF;
			end
		endcase
		// halt wins over every transition except start out of off, beacon loop included
		if (ctrl_ff[`RTSEQ_CTRL_HALT] && state_ff != rtseq_pkg::RTSEQ_OFF) begin
			nxt_state = rtseq_pkg::RTSEQ_OFF;
			tstop = 1'b1;
			t1_load = 1'b0;
			t2_load = 1'b0;
			rxto_load = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= rtseq_pkg::RTSEQ_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// preamble seen in this receive slot extends it to t2 end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_seen_ff <= 1'b0;
		end else if (state_ff == rtseq_pkg::RTSEQ_RX && preamble_found) begin
			pre_seen_ff <= 1'b1;
		end else if (state_ff != rtseq_pkg::RTSEQ_RX) begin
			pre_seen_ff <= 1'b0;
		end
	end

	// receive latch: after sequencer off the radio keeps receiving
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			listen_ff <= 1'b0;
		end else if (state_ff == rtseq_pkg::RTSEQ_RX && nxt_state == rtseq_pkg::RTSEQ_OFF
			&& !ctrl_ff[`RTSEQ_CTRL_HALT]) begin
			listen_ff <= 1'b1;
		end else if (start_pulse || ctrl_ff[`RTSEQ_CTRL_HALT]) begin
			listen_ff <= 1'b0;
		end
	end

	// sticky event flags; a new event wins over the clearing write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_flag_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			if (state_ff == rtseq_pkg::RTSEQ_RX && sync_word_match) begin
				sync_flag_ff <= 1'b1;
			end else if (start_pulse) begin
				sync_flag_ff <= 1'b0;
			end
			if ((listen_ff || state_ff == rtseq_pkg::RTSEQ_RX) && payload_complete) begin
				irq_ff <= 1'b1;
			end else if (start_pulse) begin
				irq_ff <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// radio controls and pins
	// ---------------------------------------------------------------
	// idle keeps only the rc oscillator alive when power choice is 1
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_on <= 1'b0;
			tx_on <= 1'b0;
			rc_osc_on <= 1'b0;
			xtal_on <= 1'b0;
			beacon_repeat_enable <= 1'b0;
			event_pin_four <= 1'b0;
			packet_irq <= 1'b0;
		end else begin
			rx_on <= (nxt_state == rtseq_pkg::RTSEQ_RX) || (nxt_state == rtseq_pkg::RTSEQ_OFF
				&& (listen_ff || (state_ff == rtseq_pkg::RTSEQ_RX
				&& !ctrl_ff[`RTSEQ_CTRL_HALT])));
			tx_on <= (nxt_state == rtseq_pkg::RTSEQ_TX);
			rc_osc_on <= (nxt_state != rtseq_pkg::RTSEQ_OFF);
			xtal_on <= !((nxt_state == rtseq_pkg::RTSEQ_IDLE
				&& cfg_ff[`RTSEQ_CFG_IDLE_POWER]) || nxt_state == rtseq_pkg::RTSEQ_OFF);
			beacon_repeat_enable <= ctrl_ff[`RTSEQ_CTRL_BEACON];
			event_pin_four <= ctrl_ff[`RTSEQ_CTRL_ROUTE] && preamble_found;
			packet_irq <= irq_ff;
		end
	end
endmodule
`default_nettype wire

/* File: verif/rtseq_asserts.sv */
// checker for the radio top sequencer outputs
`timescale 1ns/1ns
`default_nettype none
module rtseq_asserts (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, low
	input wire logic preamble_found, // radio event
	input wire logic payload_complete, // radio event
	input wire logic packet_done, // radio event
	input wire logic rx_on, // receiver on
	input wire logic tx_on, // transmitter on
	input wire logic rc_osc_on, // rc oscillator on
	input wire logic xtal_on, // crystal path on
	input wire logic event_pin_four, // preamble pin
	input wire logic packet_irq // packet request
);
	// ------------------------------------------------------------
	// sequencer relations, all in the bus clock domain
	// ------------------------------------------------------------
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_tx_end; tx_on && packet_done |=> !tx_on; endproperty
	a_tx_end: assert property (p_tx_end) else $error("tx held after done");
	property p_rx_keep; rx_on && preamble_found |=> rx_on; endproperty
	a_rx_keep: assert property (p_rx_keep) else $error("rx lost on preamble");
	property p_pin; event_pin_four |-> $past(preamble_found); endproperty
	a_pin: assert property (p_pin) else $error("pin without preamble");
	property p_irq; $rose(packet_irq) |-> $past(payload_complete, 2); endproperty
	a_irq: assert property (p_irq) else $error("request without packet");
	property p_excl; !(rx_on && tx_on); endproperty
	a_excl: assert property (p_excl) else $error("rx and tx together");
	// leaving the crystal on would waste the sleep saving
	property p_sleep; $fell(xtal_on) && rc_osc_on |-> !rx_on && !tx_on; endproperty
	a_sleep: assert property (p_sleep) else $error("radio on in sleep");
	property p_rx_wake; $rose(rx_on) |-> $past(rc_osc_on) && !$past(tx_on); endproperty
	a_rx_wake: assert property (p_rx_wake) else $error("rx not from idle");
	property p_tx_wake; $rose(tx_on) |-> $past(rc_osc_on) && !$past(rx_on); endproperty
	a_tx_wake: assert property (p_tx_wake) else $error("tx not from idle");
endmodule
bind rtseq_top rtseq_asserts i_rtseq_asserts (.hclk(hclk), .hresetn(hresetn),
	.preamble_found(preamble_found), .payload_complete(payload_complete),
	.packet_done(packet_done), .rx_on(rx_on), .tx_on(tx_on), .rc_osc_on(rc_osc_on),
	.xtal_on(xtal_on), .event_pin_four(event_pin_four), .packet_irq(packet_irq));
`default_nettype wire

/* File: verif/rtseq_radio_model.sv */
// radio front-end model that raises the sequencer events
`timescale 1ns/1ns
`default_nettype none
module rtseq_radio_model (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, low
	input wire logic rx_on, // receiver on
	input wire logic tx_on, // transmitter on
	input wire logic [2:0] arm, // b0 preamble b1 sync b2 payload
	input wire logic [3:0] gap, // cycles from turn-on to preamble, and from preamble to sync
	output logic preamble_found, // one-cycle pulse
	output logic sync_word_match, // one-cycle pulse
	output logic payload_complete, // one-cycle pulse when gap is below 15
	output logic packet_done // one-cycle pulse
);
	logic [4:0] cnt_ff;
	// ------------------------------------------------------------
	// events timed from the moment the radio path turns on
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= 5'h00;
			preamble_found <= 1'b0;
			sync_word_match <= 1'b0;
			payload_complete <= 1'b0;
			packet_done <= 1'b0;
		end else begin
			// saturating at 31, so a long receive repeats no event, except payload_complete every cycle when gap is 15
			cnt_ff <= (rx_on || tx_on) ? cnt_ff + {4'h0, cnt_ff != 5'h1f} : 5'h00;
			preamble_found <= rx_on && arm[0] && cnt_ff == {1'b0, gap};
			sync_word_match <= rx_on && arm[1] && cnt_ff == {gap, 1'b0};
			payload_complete <= rx_on && arm[2] && cnt_ff == {gap, 1'b1};
			packet_done <= tx_on && cnt_ff == {1'b0, gap};
		end
	end
endmodule
`default_nettype wire

/* File: verif/rtseq_top_tb.sv */
// self-checking bench for the radio top sequencer
`timescale 1ns/1ns
`default_nettype none
`include "rtseq_defs.svh"
module rtseq_top_tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin_seen;
	logic pre, syn, pay, pkt, rx_on, tx_on, rc_osc_on, xtal_on, beacon, pin, irq;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize, arm;
	logic [3:0] gap;
	logic [31:0] hwdata, hrdata, r;
	logic [11:0] ra[6] = '{`RTSEQ_OFS_CFG, `RTSEQ_OFS_FIRST_INTERVAL_TIMER, `RTSEQ_OFS_SECOND_INTERVAL_TIMER,
		`RTSEQ_OFS_RXTO, `RTSEQ_OFS_STATUS, 12'h100};
	logic [31:0] rv[6] = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0};
	int fail_count, num_checks, cyc, n;

	rtseq_top #(.TW(16), .RC_DIV(2)) i_rtseq_top (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .preamble_found(pre), .sync_word_match(syn),
		.payload_complete(pay), .packet_done(pkt), .rx_on(rx_on), .tx_on(tx_on),
		.rc_osc_on(rc_osc_on), .xtal_on(xtal_on), .beacon_repeat_enable(beacon),
		.event_pin_four(pin), .packet_irq(irq));
	rtseq_radio_model i_rtseq_radio_model (.hclk(hclk), .hresetn(hresetn),
		.rx_on(rx_on), .tx_on(tx_on), .arm(arm), .gap(gap), .preamble_found(pre),
		.sync_word_match(syn), .payload_complete(pay), .packet_done(pkt));

	// ------------------------------------------------------------
	// clock, hang guard and pin monitor
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (pin === 1'b1)
			pin_seen <= 1'b1;
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one single transfer; read data lands in r
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	// waits for rx (t=0) or tx (t=1) to reach v; n counts the cycles
	task automatic wait_for(input bit t, input logic v, input int lim);
		n = 0;
		while ((t ? tx_on : rx_on) !== v && n < lim) begin
			@(posedge hclk);
			n++;
		end
		if (lim == 500 && n == 500)
			check("wait_timeout", 32'h1, 32'h0);
	endtask
	task automatic setup(input logic [31:0] c, t1, t2, to, ctl);
		bus(1'b1, `RTSEQ_OFS_CFG, c);
		bus(1'b1, `RTSEQ_OFS_FIRST_INTERVAL_TIMER, t1);
		bus(1'b1, `RTSEQ_OFS_SECOND_INTERVAL_TIMER, t2);
		bus(1'b1, `RTSEQ_OFS_RXTO, to);
		bus(1'b1, `RTSEQ_OFS_CTRL, ctl);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		arm = 3'h0;
		gap = 4'h2;
		pin_seen = 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values, unmapped write must not stick
		bus(1'b1, 12'h100, 32'hffffffff);
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ra[i], 32'h0);
			check("reset_value", r, rv[i]);
		end
		check("hresp_okay", hresp, 1'b0);
		// wake on preamble: one empty poll, then the preamble holds rx
		setup(32'h0d9, 32'h4, 32'h3, 32'h40, 32'h9);
		wait_for(0, 1'b1, 500);
		wait_for(0, 1'b0, 500);
		check("rx_len", n inside {[5:8]}, 1);
		bus(1'b0, `RTSEQ_OFS_STATUS, 32'h0);
		check("idle_state", r[6:0], rtseq_pkg::RTSEQ_IDLE);
		check("xtal_idle", xtal_on, 1'b0);
		check("rc_idle", rc_osc_on, 1'b1);
		arm <= 3'h1;
		wait_for(0, 1'b1, 500);
		check("idle_len", n inside {[5:11]}, 1);
		repeat (40) @(posedge hclk);
		check("rx_held", rx_on, 1'b1);
		check("seq_off", rc_osc_on, 1'b0);
		check("pin_pulse", pin_seen, 1'b1);
		bus(1'b0, `RTSEQ_OFS_STATUS, 32'h0);
		// preamble seen only stands while receiving; off with rx latched
		check("status_pre", r[9:0], 10'h001);
		// wake on sync: short window, preamble stretch, then sync match
		arm <= 3'h0;
		gap <= 4'h1;
		setup(32'h2b9, 32'h2, 32'h8, 32'h3, 32'h1);
		wait_for(0, 1'b0, 500);
		wait_for(0, 1'b1, 500);
		wait_for(0, 1'b0, 500);
		check("window_len", n inside {[4:8]}, 1);
		arm <= 3'h1;
		wait_for(0, 1'b1, 500);
		wait_for(0, 1'b0, 500);
		check("stretch_len", n inside {[14:18]}, 1);
		arm <= 3'h7;
		wait_for(0, 1'b1, 500);
		repeat (40) @(posedge hclk);
		check("rx_sync", rx_on, 1'b1);
		check("irq", irq, 1'b1);
		bus(1'b0, `RTSEQ_OFS_STATUS, 32'h0);
		check("status_sync", r[9:0], 10'h301);
		// beacon: three transmits of gap+2 cycles, then halt
		arm <= 3'h0;
		gap <= 4'h5;
		setup(32'h009, 32'h4, 32'h8, 32'h1, 32'h5);
		wait_for(0, 1'b0, 500);
		for (int i = 0; i < 3; i++) begin
			wait_for(1, 1'b1, 500);
			wait_for(1, 1'b0, 500);
			check("tx_len", n, 7);
		end
		check("repeat_en", beacon, 1'b1);
		bus(1'b1, `RTSEQ_OFS_CTRL, 32'h6);
		// the state takes the halt one edge after the write lands
		@(posedge hclk);
		bus(1'b0, `RTSEQ_OFS_STATUS, 32'h0);
		check("halt_state", r[6:0], rtseq_pkg::RTSEQ_OFF);
		wait_for(1, 1'b1, 200);
		check("halt_quiet", n, 200);
		print_verdict();
	end
endmodule
`default_nettype wire
